// ==== bench/svwr_proc_model.sv ====
/* Processor model that services the supervisor watchdog.
   Assumes kick_gap stays below the selected timeout unless a stall is
   wanted; 0 stalls the kicks. */
`timescale 1ns/1ns
module svwr_proc_model (
  input  wire logic        sys_clk,     // system clock
  input  wire logic        reset_out_n, // reset from supervisor
  input  wire logic [15:0] kick_gap,    // cycles between edges, 0 stalls
  output logic             kick_input   // kick to supervisor
);
  logic [15:0] cnt_r;
  initial kick_input = 1'b1;
  initial cnt_r = 16'h0000;
  // code restarts while held in reset, so the gap counts from release
  always @(posedge sys_clk) begin
    if (!reset_out_n || kick_gap == 16'h0000) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r + 16'h0001 >= kick_gap) begin
      cnt_r <= 16'h0000;
      kick_input <= ~kick_input;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // svwr_proc_model

// ==== bench/tb_svwr_top.sv ====
/* Self-checking bench, simple and windowed variants with short periods.
   Assumes the processor model drives the kick; reset pulses are timed. */
`timescale 1ns/1ns
module tb_svwr_top;
  localparam int HOLD = 40;
  localparam int WD   = 30;
  localparam int MR   = int'(svwr_pkg::MR_MIN_CYC);
  logic        sys_clk, rst_n, supply_low, aux_low, manual_reset_n;
  logic        period_select, kick_input, reset_out_n, wd_fault, flt;
  logic        strap_lo, strap_hi, kick_w, reset_w_n, fault_w, flt_w;
  logic [15:0] kick_gap, kick_gap_w;
  logic [31:0] seed;
  int          miscompares, num_checks, len, len_w, n;
  int          q_len[$], q_len_w[$];
  logic        q_flt[$], q_flt_w[$];

  svwr_top #(.RESET_HOLD(40'h28), .BASIC_WD(40'h1E)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .supply_low(supply_low), .aux_low(aux_low),
    .manual_reset_n(manual_reset_n), .kick_input(kick_input),
    .period_select(period_select), .ratio_strap_lo(strap_lo),
    .ratio_strap_hi(strap_hi), .reset_out_n(reset_out_n), .wd_fault(wd_fault));
  svwr_proc_model cpu (.sys_clk(sys_clk), .reset_out_n(reset_out_n),
    .kick_gap(kick_gap), .kick_input(kick_input));
  // windowed variant shares the supply, aux and manual conditions
  svwr_top #(.WINDOWED(1'b1), .RESET_HOLD(40'h28), .SLOW_LIM(40'h100))
    dut_w (.sys_clk(sys_clk), .rst_n(rst_n), .supply_low(supply_low),
    .aux_low(aux_low), .manual_reset_n(manual_reset_n),
    .kick_input(kick_w), .period_select(period_select),
    .ratio_strap_lo(strap_lo), .ratio_strap_hi(strap_hi),
    .reset_out_n(reset_w_n), .wd_fault(fault_w));
  svwr_proc_model cpu_w (.sys_clk(sys_clk), .reset_out_n(reset_w_n),
    .kick_gap(kick_gap_w), .kick_input(kick_w));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // w: 0 simple only, 1 windowed only, 2 both variants
  task automatic expect_pulse(input int l, input logic f, input int w);
    if (w != 1) begin
      q_len.push_back(l);
      q_flt.push_back(f);
    end
    if (w != 0) begin
      q_len_w.push_back(l);
      q_flt_w.push_back(f);
    end
  endtask
  // hold one reset condition for c cycles, then drop it
  task automatic pulse_cond(input int sel, input int c);
    @(posedge sys_clk);
    if (sel == 0) supply_low <= 1'b1;
    else if (sel == 1) aux_low <= 1'b1;
    else manual_reset_n <= 1'b0;
    cyc(c);
    supply_low <= 1'b0;
    aux_low <= 1'b0;
    manual_reset_n <= 1'b1;
  endtask
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // time each reset pulse; sync delay gives a few cycles of slack
  always @(posedge sys_clk) begin
    if (rst_n && reset_out_n === 1'b0) begin
      len <= len + 1;
      flt <= flt | (wd_fault === 1'b1);
    end else if (rst_n && len > 0) begin
      num_checks++;
      if (q_len.size() == 0) begin
        miscompares++;
        $display("ERROR reset_pulse expected none seen %0d", len);
      end else begin
        if (len < q_len[0] - 1 || len > q_len[0] + 5 ||
            flt !== q_flt[0]) begin
          miscompares++;
          $display("ERROR reset_pulse expected %0d/%b seen %0d/%b",
            q_len[0], q_flt[0], len, flt);
        end
        q_len.pop_front();
        q_flt.pop_front();
      end
      len <= 0;
      flt <= 1'b0;
    end
  end

  // same timing of each windowed-variant reset pulse
  always @(posedge sys_clk) begin
    if (rst_n && reset_w_n === 1'b0) begin
      len_w <= len_w + 1;
      flt_w <= flt_w | (fault_w === 1'b1);
    end else if (rst_n && len_w > 0) begin
      num_checks++;
      if (q_len_w.size() == 0) begin
        miscompares++;
        $display("ERROR reset_pulse_w expected none seen %0d", len_w);
      end else begin
        if (len_w < q_len_w[0] - 1 || len_w > q_len_w[0] + 5 ||
            flt_w !== q_flt_w[0]) begin
          miscompares++;
          $display("ERROR reset_pulse_w expected %0d/%b seen %0d/%b",
            q_len_w[0], q_flt_w[0], len_w, flt_w);
        end
        q_len_w.pop_front();
        q_flt_w.pop_front();
      end
      len_w <= 0;
      flt_w <= 1'b0;
    end
  end

  initial begin
    rst_n = 1'b0;
    supply_low = 1'b0;
    aux_low = 1'b0;
    manual_reset_n = 1'b1;
    period_select = 1'b0;
    strap_lo = 1'b0;
    strap_hi = 1'b0;
    kick_gap = 16'h0014;
    kick_gap_w = 16'h0028;
    miscompares = 0;
    num_checks = 0;
    len = 0;
    len_w = 0;
    flt = 1'b0;
    flt_w = 1'b0;
    seed = 32'h00010755;
    expect_pulse(HOLD, 1'b0, 2);
    cyc(12);
    rst_n <= 1'b1;
    cyc(200);
    for (int s = 0; s < 3; s++) begin
      seed = xs(seed);
      n = 100 + int'(seed[5:0]);
      kick_gap <= 16'h000A + {12'h000, seed[9:6]};
      // manual reset only counts once the filter has seen MR low cycles
      if (s == 2) begin
        expect_pulse(n - MR + HOLD, 1'b0, 2);
      end else begin
        expect_pulse(n + HOLD, 1'b0, 2);
      end
      pulse_cond(s, n);
      // straps move only while reset is low, so no window restarts
      {strap_hi, strap_lo} <= seed[11:10];
      cyc(HOLD + 30);
    end
    pulse_cond(2, 50);
    cyc(20);
    kick_gap <= 16'h0000;
    expect_pulse(HOLD, 1'b1, 0);
    cyc(WD + 10);
    kick_gap <= 16'h0014;
    cyc(HOLD + 20);
    period_select <= 1'b1;
    kick_gap <= 16'h00C8;
    cyc(1000);
    kick_gap <= 16'h0000;
    cyc(3000);
    expect_pulse(HOLD, 1'b1, 0);
    cyc(950);
    for (int t = 0; t < 8; t++) begin
      period_select <= ~period_select;
      cyc(20);
    end
    period_select <= 1'b0;
    expect_pulse(HOLD, 1'b1, 0);
    cyc(WD + 10);
    kick_gap <= 16'h0014;
    cyc(HOLD + 20);
    // windowed: late kick, early kick, ratio 64, disabled, ratio 16
    kick_gap_w <= 16'h0000;
    {strap_hi, strap_lo} <= svwr_pkg::STRAP_R8;
    expect_pulse(HOLD, 1'b1, 1);
    wait (reset_w_n === 1'b0);
    @(posedge sys_clk);
    kick_gap_w <= 16'h0028;
    cyc(HOLD + 100);
    kick_gap_w <= 16'h0005;
    expect_pulse(HOLD, 1'b1, 1);
    wait (reset_w_n === 1'b0);
    @(posedge sys_clk);
    {strap_hi, strap_lo} <= svwr_pkg::STRAP_R64;
    cyc(HOLD + 300);
    {strap_hi, strap_lo} <= svwr_pkg::STRAP_OFF;
    kick_gap_w <= 16'h0000;
    cyc(400);
    {strap_hi, strap_lo} <= svwr_pkg::STRAP_R16;
    kick_gap_w <= 16'h0005;
    expect_pulse(HOLD, 1'b1, 1);
    wait (reset_w_n === 1'b0);
    @(posedge sys_clk);
    kick_gap_w <= 16'h0028;
    cyc(HOLD + 100);
    for (int w = 0; w < 200 && q_len.size() + q_len_w.size() > 0; w++) begin
      cyc(1);
    end
    // a pulse that never came is a mismatch too
    if (q_len.size() + q_len_w.size() != 0) begin
      miscompares++;
      $display("ERROR reset_pulse expected %0d more seen 0",
        q_len.size() + q_len_w.size());
    end
    close_out();
  end

  initial begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule // tb_svwr_top

// ==== design/svwr_pkg.sv ====
/*
  Constants and timing figures of the supervisor reset and watchdog.
  Assumes a 100 MHz system clock; comparator results arrive as digital levels.
*/
// What this block does
// R1 - period select low uses basic period
// R2 - period select high multiplies period by 128
// R3 - period select change clears watchdog timer
// R4 - missing kick transition causes reset
// R5 - kick transition or reset clears timer
// R6 - windowed: early or late kick forces reset
// R7 - windowed: timer counts only after release
// R8 - windowed: valid kick or reset clears timer
// R9 - low supply, aux or manual forces reset
// R10 - hold reset for timeout after conditions clear
// R11 - watchdog fault gives reset timeout pulse
// R12 - either comparator low asserts reset
// R13 - straps pick window ratio or disable
// R14 - straps: 00=8, hi only=16, 11=64, lo only=off
// R15 - windowed: ignore kicks while reset asserted
// R16 - manual reset must stay low 1 us
// R17 - periods are cycle-count parameters, fast derived
// R18 - all pin inputs synchronised before use
package svwr_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned MR_MIN_NS     = 1000;   // manual reset least low
  localparam int unsigned MR_MIN_CYC    = (MR_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EXT_MULT      = 128;
  localparam int unsigned RATIO_8       = 8;
  localparam int unsigned RATIO_16      = 16;
  localparam int unsigned RATIO_64      = 64;
  localparam int unsigned CNT_W         = 40;
  localparam int unsigned MR_W          = 8;
  localparam logic [1:0]  SYNC_RST      = 2'h3;   // pins idle high
  localparam logic [1:0]  STRAP_R8      = 2'h0;   // {hi,lo}
  localparam logic [1:0]  STRAP_R16     = 2'h2;
  localparam logic [1:0]  STRAP_OFF     = 2'h1;
  localparam logic [1:0]  STRAP_R64     = 2'h3;
endpackage : svwr_pkg

// ==== design/svwr_sync.sv ====
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes inputs are asynchronous to sys_clk.
*/
`timescale 1ns/1ns
module svwr_sync #(
  parameter int unsigned W = 5
) (
  input  wire logic         sys_clk,  // system clock
  input  wire logic         rst_n,    // async reset, active low
  input  wire logic [W-1:0] pin_in,   // raw pins
  output logic      [W-1:0] pin_sync  // synchronised pins
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } svwr_sync_st_t;
  svwr_sync_st_t st_r, st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt.meta = pin_in;    // R18
    st_nxt.sync = st_r.meta;
  end

  // pins idle high so reset to ones
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_sync = st_r.sync;
endmodule // svwr_sync

// ==== design/svwr_top.sv ====
/*
  Supervisor reset generator with simple or windowed watchdog.
  Assumes comparator and strap levels are asynchronous pins; one clock.
*/
`timescale 1ns/1ns
module svwr_top #(
  parameter bit              WINDOWED   = 1'b0,     // variant select
  parameter logic [39:0]     RESET_HOLD = 40'h4E20, // reset timeout cycles
  parameter logic [39:0]     BASIC_WD   = 40'h3E80, // basic period cycles
  parameter logic [39:0]     SLOW_LIM   = 40'hFA00  // slow limit cycles
) (
  input  wire logic sys_clk,        // 100 MHz clock
  input  wire logic rst_n,          // async reset, active low
  input  wire logic supply_low,     // supply below threshold
  input  wire logic aux_low,        // aux voltage below threshold
  input  wire logic manual_reset_n, // manual reset, active low
  input  wire logic kick_input,     // processor watchdog kick
  input  wire logic period_select,  // simple: extended period
  input  wire logic ratio_strap_lo, // windowed strap, low order
  input  wire logic ratio_strap_hi, // windowed strap, high order
  output logic      reset_out_n,    // reset to processor, active low
  output logic      wd_fault        // one-cycle watchdog fault pulse
);
  localparam int unsigned CW = svwr_pkg::CNT_W;
  localparam int unsigned MW = svwr_pkg::MR_W;

  typedef enum logic [1:0] {
    SVWR_HOLD  = 2'h0,  // reset low, counting timeout
    SVWR_RUN   = 2'h1,  // reset released, watchdog live
    SVWR_FAULT = 2'h3   // watchdog fault, reload hold
  } svwr_state_t;

  typedef struct packed {
    svwr_state_t     st;
    logic [CW-1:0]   hold_cnt;
    logic [CW-1:0]   wd_cnt;
    logic [MW-1:0]   mr_cnt;
    logic            mr_act;
    logic            kick_d;
    logic            psel_d;
    logic [1:0]      strap_d;
    logic            rst_o;
    logic            fault_o;
  } svwr_regs_t;

  svwr_regs_t r_r, r_nxt;
  logic [6:0] sy;
  logic       kick_s, psel_s, mr_s, sup_s, aux_s;
  logic [1:0] strap_s;
  logic [CW-1:0] wd_lim, fast_lim;
  logic          kick_fall, kick_edge, wd_off, cond;

  // all pins through two flops before any logic
  svwr_sync #(.W(7)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   ({kick_input, period_select, manual_reset_n, ~supply_low,
                ~aux_low, ratio_strap_hi, ratio_strap_lo}), // R18
    .pin_sync (sy)
  );
  assign kick_s  = sy[6];
  assign psel_s  = sy[5];
  assign mr_s    = sy[4];
  assign sup_s   = ~sy[3];
  assign aux_s   = ~sy[2];
  assign strap_s = sy[1:0];

  // timeout limits; fast limit truncates toward zero
  always_comb begin
    wd_lim = psel_s ? CW'(BASIC_WD * svwr_pkg::EXT_MULT) : BASIC_WD; // R1 R2
    case (strap_s) // R13 R14
      svwr_pkg::STRAP_R8:  fast_lim = SLOW_LIM / svwr_pkg::RATIO_8; // R17
      svwr_pkg::STRAP_R16: fast_lim = SLOW_LIM / svwr_pkg::RATIO_16;
      svwr_pkg::STRAP_R64: fast_lim = SLOW_LIM / svwr_pkg::RATIO_64;
      default:             fast_lim = '0;
    endcase
  end
  assign wd_off    = WINDOWED && (strap_s == svwr_pkg::STRAP_OFF); // R14
  assign kick_fall = r_r.kick_d & ~kick_s;
  assign kick_edge = r_r.kick_d ^ kick_s;
  // supply and aux comparators combine with filtered manual reset
  assign cond = sup_s | aux_s | r_r.mr_act; // R9 R12

  // next state of every register
  always_comb begin
    r_nxt         = r_r;
    r_nxt.kick_d  = kick_s;
    r_nxt.psel_d  = psel_s;
    r_nxt.strap_d = strap_s;
    r_nxt.fault_o = 1'b0;
    // glitch filter: needs MR_MIN_CYC straight low cycles
    if (mr_s) begin
      r_nxt.mr_cnt = '0;
      r_nxt.mr_act = 1'b0;
    end else if (r_r.mr_cnt >= MW'(svwr_pkg::MR_MIN_CYC - 1)) begin
      r_nxt.mr_act = 1'b1; // R16
    end else begin
      r_nxt.mr_cnt = r_r.mr_cnt + 1'b1;
    end
    case (r_r.st)
      SVWR_HOLD: begin
        r_nxt.rst_o  = 1'b0;
        r_nxt.wd_cnt = '0; // R5 R8
        if (cond) begin
          r_nxt.hold_cnt = '0; // R9
        end else if (r_r.hold_cnt >= RESET_HOLD - 1) begin
          r_nxt.st    = SVWR_RUN; // R10
          r_nxt.rst_o = 1'b1;
        end else begin
          r_nxt.hold_cnt = r_r.hold_cnt + 1'b1;
        end
      end
      SVWR_RUN: begin
        r_nxt.wd_cnt = r_r.wd_cnt + 1'b1; // R7
        if (cond) begin
          r_nxt.st       = SVWR_HOLD;
          r_nxt.rst_o    = 1'b0;
          r_nxt.hold_cnt = '0;
          r_nxt.wd_cnt   = '0;
        end else if (!WINDOWED) begin
          if (kick_edge || (psel_s != r_r.psel_d)) begin
            r_nxt.wd_cnt = '0; // R3 R5
          end else if (r_r.wd_cnt >= wd_lim - 1) begin
            r_nxt.st = SVWR_FAULT; // R4
          end
        end else if (wd_off || (strap_s != r_r.strap_d)) begin
          r_nxt.wd_cnt = '0; // R13
        end else if (kick_fall) begin
          if (r_r.wd_cnt < fast_lim) begin
            r_nxt.st = SVWR_FAULT; // R6
          end else begin
            r_nxt.wd_cnt = '0; // R8
          end
        end else if (r_r.wd_cnt >= SLOW_LIM - 1) begin
          r_nxt.st = SVWR_FAULT; // R6
        end
        if (r_nxt.st == SVWR_FAULT) begin
          r_nxt.rst_o   = 1'b0;
          r_nxt.fault_o = 1'b1;
          r_nxt.wd_cnt  = '0;
        end
      end
      SVWR_FAULT: begin
        // kicks ignored while reset low
        r_nxt.st       = SVWR_HOLD; // R11 R15
        r_nxt.hold_cnt = CW'(1);
        r_nxt.rst_o    = 1'b0;
      end
      default: begin
        r_nxt.st    = SVWR_HOLD;
        r_nxt.rst_o = 1'b0;
      end
    endcase
  end

  // reset comes up with output asserted
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r         <= '0;
      r_r.st      <= SVWR_HOLD;
      r_r.kick_d  <= 1'b1;
      r_r.psel_d  <= 1'b1;
      r_r.strap_d <= svwr_pkg::SYNC_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign reset_out_n = r_r.rst_o;
  assign wd_fault    = r_r.fault_o;

  a_hold_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cond |=> !reset_out_n) else $error("reset high during condition"); // R9
  a_fault_rst: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wd_fault |-> !reset_out_n [*8]) else $error("fault pulse too short"); // R11
  a_rise_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(reset_out_n) |-> r_r.hold_cnt >= RESET_HOLD - 1)
    else $error("reset released early"); // R10
  a_wd_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reset_out_n |-> r_r.wd_cnt == '0) else $error("timer runs in reset"); // R5
  a_mr_filter: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(r_r.mr_act) |-> $past(!mr_s) && $past(!mr_s, 50) &&
    $past(!mr_s, svwr_pkg::MR_MIN_CYC))
    else $error("short manual pulse taken"); // R16
  a_fault_src: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wd_fault |-> $past(reset_out_n)) else $error("fault while in reset"); // R15
  a_psel_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!WINDOWED && reset_out_n && !cond && psel_s != r_r.psel_d)
    |=> r_r.wd_cnt == '0) else $error("select change kept timer"); // R3
  a_off_nofault: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wd_off && $past(wd_off)) |-> !wd_fault)
    else $error("fault while disabled"); // R14
  c_fault: cover property (@(posedge sys_clk) disable iff (!rst_n) wd_fault);
  c_release: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(reset_out_n));
  c_kick_ok: cover property (@(posedge sys_clk) disable iff (!rst_n)
    reset_out_n && kick_fall ##1 reset_out_n);
endmodule // svwr_top
